/* File: memmap_pkg.sv */
// constants for the banked program and data memory address map
// assumes a single core clock domain; imported by the map module only, its tests hardcode the values
package memmap_pkg;
    localparam int PC_W = 13;
    localparam int PROG_IMPL_W = 11;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam int DADDR_W = 9;
    localparam int BANK_OFS_W = 7;
    localparam logic [6:0] SFR_TOP = 7'h1f;
    localparam logic [6:0] GPR0_LO = 7'h20;
    localparam logic [6:0] GPR0_HI = 7'h7f;
    localparam logic [6:0] GPR1_LO = 7'h20;
    localparam logic [6:0] GPR1_HI = 7'h3f;
    localparam logic [6:0] SHARED_LO = 7'h70;
    localparam int BANK_LOW_BIT = 5;
    localparam int BANK_HIGH_BIT = 6;
    localparam int IND_BANK_BIT = 7;
    localparam int RAM_WORDS = 128;
    localparam int RAM_AW = 7;
    typedef enum logic [1:0] {
        REGION_SFR,
        REGION_RAM,
        REGION_NONE
    } region_t;
endpackage

/* File: banked_memory_address_map.sv */
// banked program/data address map: pc sequencing, wrap, vectors and data decode
// assumes the core drives fetch/branch/irq and data strobes on sys_clk
// Overview of operation
// - the program counter is 13 bits, spanning 8k words of 14 bits
// - only the low 2k words exist, so higher fetch addresses wrap into them
// - after reset fetching starts at program address zero
// - taking an interrupt loads the program counter with address four
// - data memory is four banks each holding special and general locations
// - the lowest 32 locations of each bank decode as special-function registers
// - general ram sits at 20h-7fh in bank zero and a0h-bfh in bank one
// - the top sixteen bytes of banks one to three alias bank zero 70h-7fh
// - reads of locations that are neither special nor ram return zero
// - direct access takes seven bits from the opcode and two from the bank bits
// - bank_sel_low is status bit 5 and bank_sel_high status bit 6
// - indirect access takes eight bits from the pointer and address bit eight from status bit 7
`timescale 1ns/100ps
module banked_memory_address_map
    import memmap_pkg::*;
#(
    parameter int RAM_DEPTH = RAM_WORDS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // program sequencing from the core
    input wire logic fetch_advance,
    input wire logic branch_load,
    input wire logic [PC_W-1:0] branch_target,
    input wire logic irq_take,
    // program memory address
    output logic [PC_W-1:0] pc,
    output logic [PROG_IMPL_W-1:0] prog_addr,
    // data access from the core
    input wire logic data_indirect,
    input wire logic [BANK_OFS_W-1:0] opcode_addr,
    input wire logic [7:0] indirect_pointer_reg,
    input wire logic [7:0] status_reg,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic [7:0] sfr_rdata,
    // data decode results
    output logic [DADDR_W-1:0] data_addr,
    output logic sfr_sel,
    output logic [7:0] data_rdata
);
    initial begin
        if (RAM_DEPTH != RAM_WORDS) begin
            $error("ram depth must equal the mapped general ram size");
        end
    end

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [7:0] rdata;
    } state_t;

    state_t st;
    state_t next_st;
    logic [7:0] ram [RAM_DEPTH];
    logic bank_sel_low;
    logic bank_sel_high;
    logic indirect_bank_bit;
    logic [BANK_OFS_W-1:0] ofs;
    logic [1:0] bank;
    region_t region;
    logic [RAM_AW-1:0] ram_idx;

    // bank bits are read straight from status, so a write lands on the next access
    assign bank_sel_low = status_reg[BANK_LOW_BIT];
    assign bank_sel_high = status_reg[BANK_HIGH_BIT];
    assign indirect_bank_bit = status_reg[IND_BANK_BIT];

    always_comb begin
        if (data_indirect) begin
            data_addr = {indirect_bank_bit, indirect_pointer_reg};
        end else begin
            data_addr = {bank_sel_high, bank_sel_low, opcode_addr};
        end
    end

    assign ofs = data_addr[BANK_OFS_W-1:0];
    assign bank = data_addr[DADDR_W-1:BANK_OFS_W];

    // ram index: bank zero ram 20h-7fh indexes by ofs; bank one 20h-3fh gives index 40h-5fh, replaced below
    always_comb begin
        region = REGION_NONE;
        ram_idx = ofs;
        if (ofs <= SFR_TOP) begin
            region = REGION_SFR;
        end else if (bank == 2'b00) begin
            region = REGION_RAM;
        end else if (ofs >= SHARED_LO) begin
            region = REGION_RAM;
        end else if (bank == 2'b01 && ofs >= GPR1_LO && ofs <= GPR1_HI) begin
            region = REGION_RAM;
            ram_idx = {1'b0, ofs[5:0]} + 7'h00;
            ram_idx[RAM_AW-1] = 1'b1;
            ram_idx[RAM_AW-2] = 1'b0;
        end
    end
    // bank one private bytes reuse bank zero's unused 00h-1fh ram slots by clearing the top two index bits
    // 0x40|ofs[4:0] would clash, so index 0x00-0x1f (sfr space, never ram in bank 0)
    logic [RAM_AW-1:0] ram_addr;
    assign ram_addr = (bank == 2'b01 && ofs < SHARED_LO && ofs > SFR_TOP)
                    ? {2'b00, ofs[4:0]} : ram_idx;

    assign sfr_sel = (region == REGION_SFR) && (data_rd || data_wr);

    always_ff @(posedge sys_clk) begin
        if (data_wr && region == REGION_RAM) begin
            ram[ram_addr] <= data_wdata;
        end
    end

    always_comb begin
        next_st = st;
        if (irq_take) begin
            next_st.pc = IRQ_VECTOR;
        end else if (branch_load) begin
            next_st.pc = branch_target;
        end else if (fetch_advance) begin
            next_st.pc = st.pc + 13'h0001;
        end
        if (data_rd) begin
            unique case (region)
                REGION_SFR: next_st.rdata = sfr_rdata;
                REGION_RAM: next_st.rdata = ram[ram_addr];
                REGION_NONE: next_st.rdata = 8'h00;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st.pc <= RESET_VECTOR;
            st.rdata <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    assign pc = st.pc;
    // upper pc bits are ignored by the array, so high fetches wrap
    assign prog_addr = st.pc[PROG_IMPL_W-1:0];
    assign data_rdata = st.rdata;
endmodule

/* File: core_sfr_model.sv */
// far-side core stand-in: sfr read data
// assumes the bench samples it at the read edge
`timescale 1ns/100ps
module core_sfr_model (
    input logic sys_clk,
    output logic [7:0] sfr_rdata = 8'h5a
);
    // a new byte every cycle, so a stale capture shows
    always @(posedge sys_clk) sfr_rdata <= sfr_rdata + 8'h3b;
endmodule

/* File: banked_memory_address_map_monitor.sv */
// checks on the map ports: pc sequencing and data decode
// assumes one clock domain; bound below
`timescale 1ns/100ps
module banked_memory_address_map_monitor (
    input logic sys_clk, rst_b, fetch_advance, branch_load, irq_take, data_indirect,
    input logic data_rd, data_wr, sfr_sel,
    input logic [12:0] pc,
    input logic [10:0] prog_addr,
    input logic [6:0] opcode_addr,
    input logic [7:0] indirect_pointer_reg, status_reg, sfr_rdata, data_rdata, data_wdata,
    input logic [8:0] data_addr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_w; prog_addr == pc[10:0]; endproperty
    a_w: assert property (p_w) else $error("wrap");
    property p_i; irq_take |=> pc == 13'h0004; endproperty
    a_i: assert property (p_i) else $error("vector");
    property p_a; fetch_advance & !(branch_load | irq_take) |=> pc == $past(pc) + 13'h1;
    endproperty
    a_a: assert property (p_a) else $error("advance");
    property p_d; !data_indirect |-> data_addr == {status_reg[6:5], opcode_addr}; endproperty
    a_d: assert property (p_d) else $error("direct");
    property p_n; data_indirect |-> data_addr == {status_reg[7], indirect_pointer_reg};
    endproperty
    a_n: assert property (p_n) else $error("indirect");
    property p_s; data_rd && data_addr[6:5] == 0 |-> sfr_sel ##1 data_rdata == $past(sfr_rdata);
    endproperty
    a_s: assert property (p_s) else $error("sfr");
    property p_z; data_rd && data_addr[8] && data_addr[6:5] != 0 && data_addr[6:4] != 7
        |=> data_rdata == 8'h00; endproperty
    a_z: assert property (p_z) else $error("zero");
    property p_l; data_wr && data_addr[6:4] == 7 ##1 data_rd && data_addr[6:0] ==
        $past(data_addr[6:0]) |=> data_rdata == $past(data_wdata, 2); endproperty
    a_l: assert property (p_l) else $error("alias");
endmodule
bind banked_memory_address_map banked_memory_address_map_monitor monitor_inst (.*);

/* File: banked_memory_address_map_bench.sv */
// random write-then-read pairs with pc control, checked against a byte model
// assumes core_sfr_model and the bound monitor
`timescale 1ns/100ps
module banked_memory_address_map_bench;
`define CK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
    logic sys_clk = 0, rst_b = 0, fetch_advance = 0, branch_load = 0, irq_take = 0;
    logic data_indirect = 0, data_rd = 0, data_wr = 0, sfr_sel;
    logic [12:0] branch_target = 0, pc, ep = 0;
    logic [10:0] prog_addr;
    logic [6:0] opcode_addr = 0;
    logic [7:0] indirect_pointer_reg = 0, status_reg = 0, data_wdata = 0;
    logic [7:0] sfr_rdata, data_rdata, mem[512];
    logic [8:0] data_addr, a;
    logic [31:0] seed = 53038, r;
    int bad_count = 0, compares = 0, cyc = 0;
    always #10 sys_clk = ~sys_clk;
    banked_memory_address_map banked_memory_address_map_inst (.*);
    core_sfr_model core_sfr_model_inst (.*);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // shared top bytes collapse onto bank zero
    function automatic logic [8:0] cn(input logic [8:0] x);
        return x[6:4] == 7 ? {2'h0, x[6:0]} : x;
    endfunction
    function automatic logic im(input logic [8:0] x);
        return x[6:5] != 0 && (x[8:7] == 0 || x[6:4] == 7 || x[8:7] == 1 && x[6:5] == 1);
    endfunction
    task automatic acc(input logic w, input logic [8:0] x, input logic [7:0] d);
        logic [7:0] s;
        r = xs();
        data_indirect = r[31];
        status_reg = {x[8], r[31] ? r[6:5] : x[8:7], r[4:0]};
        indirect_pointer_reg = r[31] ? x[7:0] : r[15:8];
        opcode_addr = x[6:0];
        data_wr = w;
        data_rd = !w;
        data_wdata = d;
        fetch_advance = r[20];
        branch_load = r[21] & r[22];
        irq_take = r[23] & r[24] & r[25];
        // often branch to the top word so the next advance wraps
        branch_target = r[26] ? 13'h1fff : r[31:19];
        s = sfr_rdata;
        @(negedge sys_clk);
        ep = irq_take ? 13'h0004 : branch_load ? branch_target : ep + fetch_advance;
        `CK(pc, ep)
        `CK(prog_addr, ep[10:0])
        if (w && im(x)) mem[cn(x)] = d;
        if (!w) `CK(data_rdata, x[6:5] == 0 ? s : im(x) ? mem[cn(x)] : 8'h00)
    endtask
    task print_verdict();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(negedge sys_clk);
        rst_b = 1;
        `CK(pc, 13'h0000)
        for (int i = 0; i < 400; i++) begin
            a = xs();
            acc(1, a, r[16:9]);
            acc(0, a[6:4] == 7 ? {r[10:9], a[6:0]} : a, 8'h00);
        end
        print_verdict();
    end
endmodule
